// >>> core/adcrs_sequencer.sv
`default_nettype none
module adcrs_sequencer #(
  parameter int SETTLE_PERIODS = adcrs_pkg::ADCRS_SETTLE_PERIODS,
  parameter int POWERDOWN_PERIODS = adcrs_pkg::ADCRS_POWERDOWN_PERIODS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_good,
  input wire logic reset_pin_n,
  input wire logic role_slave,
  input wire logic rate_select_bit2,
  input wire logic rate_select_bit1,
  input wire logic rate_select_bit0,
  input wire logic format_select_bit1,
  input wire logic format_select_bit0,
  input wire logic frame_clock,
  input wire logic mod_left_bit,
  input wire logic mod_right_bit,
  output logic [1:0] rate_class,
  output logic [7:0] mod_ratio,
  output logic [9:0] sys_ratio,
  output logic one_bit_stream_mode,
  output logic config_error,
  output logic reset_active,
  output logic output_zero,
  output logic data_valid,
  output logic powered_down,
  output logic sample_strobe,
  output logic stream_left_out,
  output logic stream_right_out,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [16:0] PD_MAX = 17'(POWERDOWN_PERIODS);
  localparam logic [10:0] SETTLE_LAST = 11'(SETTLE_PERIODS - 1);

  adcrs_pkg::adcrs_cfg_t cfg;
  adcrs_pkg::adcrs_cfg_t next_cfg;
  adcrs_pkg::adcrs_state_t state;
  adcrs_pkg::adcrs_state_t next_state;
  logic [16:0] hold_cnt;
  logic [16:0] next_hold_cnt;
  logic [10:0] settle_cnt;
  logic [10:0] next_settle_cnt;
  logic tick;
  logic [9:0] measured;
  logic hold;
  logic in_reset;
  logic soft_hold;
  logic next_soft_hold;
  logic next_zero;
  logic next_left;
  logic next_right;

  function automatic logic ratio_legal(input logic [9:0] r, input logic quad);
    ratio_legal = (r == adcrs_pkg::ADCRS_FS256) || (r == adcrs_pkg::ADCRS_FS384) ||
                  (r == adcrs_pkg::ADCRS_FS512) || (r == adcrs_pkg::ADCRS_FS768) ||
                  (r == adcrs_pkg::ADCRS_FS128);
    if (quad && r != adcrs_pkg::ADCRS_FS128) begin
      ratio_legal = 1'b0;
    end
  endfunction

  function automatic adcrs_pkg::adcrs_cfg_t decode(input logic [2:0] code, input logic slave,
                                                  input logic [1:0] fmt, input logic [9:0] meas);
    adcrs_pkg::adcrs_cfg_t c;
    c = adcrs_pkg::ADCRS_CFG_RESET;
    c.stream = (fmt == adcrs_pkg::ADCRS_FMT_STREAM);
    if (!slave) begin
      case (code)
        3'h0: begin c.rate = adcrs_pkg::ADCRS_RATE_SINGLE; c.sys_ratio = adcrs_pkg::ADCRS_FS768; end
        3'h1: begin c.rate = adcrs_pkg::ADCRS_RATE_SINGLE; c.sys_ratio = adcrs_pkg::ADCRS_FS512; end
        3'h2: begin c.rate = adcrs_pkg::ADCRS_RATE_SINGLE; c.sys_ratio = adcrs_pkg::ADCRS_FS384; end
        3'h3: begin c.rate = adcrs_pkg::ADCRS_RATE_SINGLE; c.sys_ratio = adcrs_pkg::ADCRS_FS256; end
        3'h4: begin c.rate = adcrs_pkg::ADCRS_RATE_DUAL; c.sys_ratio = adcrs_pkg::ADCRS_FS384; end
        3'h5: begin c.rate = adcrs_pkg::ADCRS_RATE_DUAL; c.sys_ratio = adcrs_pkg::ADCRS_FS256; end
        3'h6: begin c.rate = adcrs_pkg::ADCRS_RATE_QUAD; c.sys_ratio = adcrs_pkg::ADCRS_FS192; end
        default: begin c.rate = adcrs_pkg::ADCRS_RATE_QUAD; c.sys_ratio = adcrs_pkg::ADCRS_FS128; end
      endcase
      // Stream rides on the dual-rate codes only
      if (c.stream && c.rate != adcrs_pkg::ADCRS_RATE_DUAL) begin
        c.error = 1'b1;
      end
    end else begin
      c.sys_ratio = meas;
      case (code)
        3'h0: c.rate = adcrs_pkg::ADCRS_RATE_SINGLE;
        3'h1: c.rate = adcrs_pkg::ADCRS_RATE_DUAL;
        3'h2: c.rate = adcrs_pkg::ADCRS_RATE_QUAD;
        default: begin
          c.rate = adcrs_pkg::ADCRS_RATE_NONE;
          c.error = 1'b1;
        end
      endcase
      // Ratio unknown until the first frame edge has been seen
      if (meas != adcrs_pkg::ADCRS_RATIO_NONE && !ratio_legal(meas, c.rate == adcrs_pkg::ADCRS_RATE_QUAD)) begin
        c.error = 1'b1;
      end
      if (c.stream) begin
        c.error = 1'b1;
        c.stream = 1'b0;
      end
    end
    case (c.rate)
      adcrs_pkg::ADCRS_RATE_SINGLE: c.mod_ratio = adcrs_pkg::ADCRS_MOD_X128;
      adcrs_pkg::ADCRS_RATE_DUAL: c.mod_ratio = adcrs_pkg::ADCRS_MOD_X64;
      adcrs_pkg::ADCRS_RATE_QUAD: c.mod_ratio = adcrs_pkg::ADCRS_MOD_X32;
      default: c.mod_ratio = adcrs_pkg::ADCRS_MOD_NONE;
    endcase
    decode = c;
  endfunction

  // Pins are decoded every cycle; the host only moves them under reset
  always_comb begin
    next_cfg = decode({rate_select_bit2, rate_select_bit1, rate_select_bit0}, role_slave,
                      {format_select_bit1, format_select_bit0}, measured);
  end

  adcrs_period_tick #(
    .RATIO_W(adcrs_pkg::ADCRS_RATIO_W)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .slave(role_slave),
    .ratio(cfg.sys_ratio),
    .frame_clock(frame_clock),
    .tick(tick),
    .measured(measured)
  );

  assign hold = !reset_pin_n || soft_hold;
  assign in_reset = !power_good || hold;

  // All timing below is counted in ticks on aclk, the system clock
  always_comb begin
    next_state = state;
    next_settle_cnt = settle_cnt;
    next_hold_cnt = hold_cnt;
    if (!hold) begin
      next_hold_cnt = '0;
    end else if (tick && hold_cnt != PD_MAX) begin
      next_hold_cnt = hold_cnt + 17'h00001;
    end
    case (state)
      adcrs_pkg::ADCRS_ST_RESET: begin
        if (hold && tick && hold_cnt == PD_MAX) begin
          next_state = adcrs_pkg::ADCRS_ST_POWERDOWN;
        end else if (!in_reset) begin
          next_state = adcrs_pkg::ADCRS_ST_RELEASE;
        end
      end
      adcrs_pkg::ADCRS_ST_RELEASE: begin
        if (in_reset) begin
          next_state = adcrs_pkg::ADCRS_ST_RESET;
        end else if (tick) begin
          next_state = adcrs_pkg::ADCRS_ST_SETTLE;
          next_settle_cnt = '0;
        end
      end
      adcrs_pkg::ADCRS_ST_SETTLE: begin
        if (in_reset) begin
          next_state = adcrs_pkg::ADCRS_ST_RESET;
        end else if (tick) begin
          next_settle_cnt = settle_cnt + 11'h001;
          if (settle_cnt == SETTLE_LAST) begin
            next_state = adcrs_pkg::ADCRS_ST_RUN;
          end
        end
      end
      adcrs_pkg::ADCRS_ST_RUN: begin
        if (in_reset) begin
          next_state = adcrs_pkg::ADCRS_ST_RESET;
        end
      end
      adcrs_pkg::ADCRS_ST_POWERDOWN: begin
        if (!hold) begin
          next_state = power_good ? adcrs_pkg::ADCRS_ST_RELEASE : adcrs_pkg::ADCRS_ST_RESET;
        end
      end
      default: next_state = adcrs_pkg::ADCRS_ST_RESET;
    endcase
    next_zero = (next_state != adcrs_pkg::ADCRS_ST_SETTLE) && (next_state != adcrs_pkg::ADCRS_ST_RUN);
    // Stream bits bypass the decimator, so gate only with stream mode and the zero force
    next_left = mod_left_bit && cfg.stream && !next_zero;
    next_right = mod_right_bit && cfg.stream && !next_zero;
  end

  // aresetn is synchronous; the host's clocks before release cover it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= adcrs_pkg::ADCRS_CFG_RESET;
      state <= adcrs_pkg::ADCRS_ST_RESET;
      hold_cnt <= '0;
      settle_cnt <= '0;
      output_zero <= 1'b1;
      reset_active <= 1'b1;
      data_valid <= 1'b0;
      powered_down <= 1'b0;
      sample_strobe <= 1'b0;
      stream_left_out <= 1'b0;
      stream_right_out <= 1'b0;
    end else begin
      cfg <= next_cfg;
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      settle_cnt <= next_settle_cnt;
      output_zero <= next_zero;
      reset_active <= next_zero;
      data_valid <= next_state == adcrs_pkg::ADCRS_ST_RUN;
      powered_down <= next_state == adcrs_pkg::ADCRS_ST_POWERDOWN;
      sample_strobe <= tick && !next_zero;
      stream_left_out <= next_left;
      stream_right_out <= next_right;
    end
  end

  assign rate_class = cfg.rate;
  assign mod_ratio = cfg.mod_ratio;
  assign sys_ratio = cfg.sys_ratio;
  assign one_bit_stream_mode = cfg.stream;
  assign config_error = cfg.error;

  // AXI4-Lite slave: one write and one read in flight
  logic aw_have;
  logic w_have;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_have;
  logic next_w_have;
  logic [3:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  adcrs_pkg::adcrs_status_t status_word;
  adcrs_pkg::adcrs_config_reg_t config_word;

  always_comb begin
    status_word = '0;
    status_word.slave = role_slave;
    status_word.stream = cfg.stream;
    status_word.rate = cfg.rate;
    status_word.config_error = cfg.error;
    status_word.powered_down = powered_down;
    status_word.data_valid = data_valid;
    status_word.state = state;
    config_word = '0;
    config_word.mod_ratio = cfg.mod_ratio;
    config_word.sys_ratio = cfg.sys_ratio;
  end

  always_comb begin
    next_aw_have = aw_have || (s_axi_awvalid && s_axi_awready);
    next_w_have = w_have || (s_axi_wvalid && s_axi_wready);
    next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_soft_hold = soft_hold;
    if (aw_have && w_have && !s_axi_bvalid) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = adcrs_pkg::ADCRS_RESP_OKAY;
      case (aw_addr)
        adcrs_pkg::ADCRS_REG_CTRL: begin
          if (w_strb[0]) begin
            next_soft_hold = w_data[0];
          end
        end
        adcrs_pkg::ADCRS_REG_STATUS, adcrs_pkg::ADCRS_REG_CONFIG, adcrs_pkg::ADCRS_REG_DETECT: ;
        default: next_bresp = adcrs_pkg::ADCRS_RESP_SLVERR;
      endcase
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready = !next_w_have && !next_bvalid;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = adcrs_pkg::ADCRS_RESP_OKAY;
      case (s_axi_araddr)
        adcrs_pkg::ADCRS_REG_CTRL: next_rdata = {31'h00000000, soft_hold};
        adcrs_pkg::ADCRS_REG_STATUS: next_rdata = status_word;
        adcrs_pkg::ADCRS_REG_CONFIG: next_rdata = config_word;
        adcrs_pkg::ADCRS_REG_DETECT: next_rdata = {22'h000000, measured};
        default: begin
          next_rdata = '0;
          next_rresp = adcrs_pkg::ADCRS_RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      soft_hold <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= adcrs_pkg::ADCRS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= adcrs_pkg::ADCRS_RESP_OKAY;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      soft_hold <= next_soft_hold;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule
`default_nettype wire

// >>> core/adcrs_pkg.sv
`default_nettype none
package adcrs_pkg;
  localparam int ADCRS_RATIO_W = 10;
  localparam int ADCRS_MOD_W = 8;
  localparam int ADCRS_ADDR_W = 4;
  localparam int ADCRS_HOLD_W = 17;
  localparam int ADCRS_SETTLE_W = 11;

  localparam logic [9:0] ADCRS_FS128 = 10'h080;
  localparam logic [9:0] ADCRS_FS192 = 10'h0c0;
  localparam logic [9:0] ADCRS_FS256 = 10'h100;
  localparam logic [9:0] ADCRS_FS384 = 10'h180;
  localparam logic [9:0] ADCRS_FS512 = 10'h200;
  localparam logic [9:0] ADCRS_FS768 = 10'h300;
  localparam logic [9:0] ADCRS_RATIO_NONE = 10'h000;
  localparam logic [9:0] ADCRS_RATIO_ONE = 10'h001;

  localparam logic [7:0] ADCRS_MOD_X128 = 8'h80;
  localparam logic [7:0] ADCRS_MOD_X64 = 8'h40;
  localparam logic [7:0] ADCRS_MOD_X32 = 8'h20;
  localparam logic [7:0] ADCRS_MOD_NONE = 8'h00;

  localparam logic [1:0] ADCRS_FMT_STREAM = 2'h3;

  localparam int ADCRS_SETTLE_PERIODS = 1116;
  localparam int ADCRS_POWERDOWN_PERIODS = 65536;

  localparam logic [3:0] ADCRS_REG_CTRL = 4'h0;
  localparam logic [3:0] ADCRS_REG_STATUS = 4'h4;
  localparam logic [3:0] ADCRS_REG_CONFIG = 4'h8;
  localparam logic [3:0] ADCRS_REG_DETECT = 4'hc;
  localparam logic [1:0] ADCRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ADCRS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ADCRS_RATE_SINGLE = 2'b00,
    ADCRS_RATE_DUAL = 2'b01,
    ADCRS_RATE_QUAD = 2'b10,
    ADCRS_RATE_NONE = 2'b11
  } adcrs_rate_t;

  typedef enum logic [2:0] {
    ADCRS_ST_RESET = 3'b000,
    ADCRS_ST_RELEASE = 3'b001,
    ADCRS_ST_SETTLE = 3'b010,
    ADCRS_ST_RUN = 3'b011,
    ADCRS_ST_POWERDOWN = 3'b100
  } adcrs_state_t;

  typedef struct packed {
    adcrs_rate_t rate;
    logic [9:0] sys_ratio;
    logic [7:0] mod_ratio;
    logic stream;
    logic error;
  } adcrs_cfg_t;

  localparam adcrs_cfg_t ADCRS_CFG_RESET = '{ADCRS_RATE_NONE, ADCRS_RATIO_NONE, ADCRS_MOD_NONE, 1'b0, 1'b0};

  typedef struct packed {
    logic [21:0] zero;
    logic slave;
    logic stream;
    adcrs_rate_t rate;
    logic config_error;
    logic powered_down;
    logic data_valid;
    adcrs_state_t state;
  } adcrs_status_t;

  typedef struct packed {
    logic [7:0] zero_hi;
    logic [7:0] mod_ratio;
    logic [5:0] zero_lo;
    logic [9:0] sys_ratio;
  } adcrs_config_reg_t;
endpackage
`default_nettype wire

// >>> core/adcrs_period_tick.sv
`default_nettype none
module adcrs_period_tick #(
  parameter int RATIO_W = adcrs_pkg::ADCRS_RATIO_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slave,
  input wire logic [RATIO_W-1:0] ratio,
  input wire logic frame_clock,
  output logic tick,
  output logic [RATIO_W-1:0] measured
);
  logic [RATIO_W-1:0] cnt;
  logic [RATIO_W-1:0] next_cnt;
  logic [RATIO_W-1:0] next_measured;
  logic frame_prev;
  logic next_tick;

  always_comb begin
    next_cnt = cnt + adcrs_pkg::ADCRS_RATIO_ONE;
    next_tick = 1'b0;
    next_measured = measured;
    if (slave) begin
      // Frame edge marks the period; spacing gives the detected ratio
      if (frame_clock && !frame_prev) begin
        next_tick = 1'b1;
        next_measured = next_cnt;
        next_cnt = '0;
      end else if (cnt == '1) begin
        // Saturate so a stopped frame clock cannot alias a legal ratio
        next_cnt = cnt;
      end
    end else if (cnt >= ratio - adcrs_pkg::ADCRS_RATIO_ONE) begin
      next_tick = 1'b1;
      next_cnt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
      tick <= 1'b0;
      measured <= '0;
      frame_prev <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
      measured <= next_measured;
      frame_prev <= frame_clock;
    end
  end
endmodule
`default_nettype wire

// >>> tb/adcrs_sequencer_sva.sv
`default_nettype none
module adcrs_sequencer_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_good,
  input wire logic reset_pin_n,
  input wire logic role_slave,
  input wire logic mod_left_bit,
  input wire logic [1:0] rate_class,
  input wire logic [9:0] sys_ratio,
  input wire logic one_bit_stream_mode,
  input wire logic reset_active,
  input wire logic output_zero,
  input wire logic data_valid,
  input wire logic powered_down,
  input wire logic sample_strobe,
  input wire logic stream_left_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_enter: assert property ((!power_good || !reset_pin_n) |-> ##[1:2] reset_active)
    else $error("reset state not entered");
  a_zero_in_reset: assert property (reset_active |-> output_zero && !data_valid)
    else $error("output not zero in reset");
  a_settle_hold: assert property ($fell(reset_active) |-> !data_valid [*8])
    else $error("valid too early");
  a_strobe_gate: assert property (sample_strobe |-> !output_zero ##1 !sample_strobe)
    else $error("bad sample strobe");
  a_stream_follow: assert property (one_bit_stream_mode && $past(one_bit_stream_mode) && !output_zero
    && !$past(output_zero) |-> stream_left_out == $past(mod_left_bit))
    else $error("stream bit not passed");
  a_pd_in_reset: assert property (powered_down |-> reset_active && !data_valid)
    else $error("power-down outside reset");
  a_pd_held: assert property ($rose(powered_down) |-> !$past(reset_pin_n) && !$past(reset_pin_n, 2))
    else $error("power-down without held reset");
  a_quad_192: assert property (sys_ratio == adcrs_pkg::ADCRS_FS192 |-> rate_class == adcrs_pkg::ADCRS_RATE_QUAD)
    else $error("192 ratio outside quad");
  a_slave_stream: assert property (role_slave && $past(role_slave) && $past(role_slave, 2) |-> !one_bit_stream_mode)
    else $error("stream mode in slave role");
  c_valid: cover property ($rose(data_valid));
  c_pd: cover property ($rose(powered_down));
  c_stream: cover property (one_bit_stream_mode && data_valid);
  c_slave: cover property (role_slave && data_valid);
endmodule

bind adcrs_sequencer adcrs_sequencer_sva adcrs_sequencer_sva_i (.aclk(aclk), .aresetn(aresetn),
  .power_good(power_good), .reset_pin_n(reset_pin_n), .role_slave(role_slave), .mod_left_bit(mod_left_bit),
  .rate_class(rate_class), .sys_ratio(sys_ratio), .one_bit_stream_mode(one_bit_stream_mode),
  .reset_active(reset_active), .output_zero(output_zero), .data_valid(data_valid), .powered_down(powered_down),
  .sample_strobe(sample_strobe), .stream_left_out(stream_left_out));
`default_nettype wire

// >>> tb/adcrs_host_model.sv
`default_nettype none
module adcrs_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic pg,
  input wire logic role,
  input wire logic [2:0] code,
  input wire logic [1:0] fmt,
  output logic power_good,
  output logic reset_pin_n,
  output logic role_slave,
  output logic [2:0] rate_select,
  output logic [1:0] format_select,
  output logic frame_clock,
  output logic mod_left_bit,
  output logic mod_right_bit
);
  // Frame of 128 clocks, the only ratio allowed for slave quad rate
  logic [6:0] fcnt;
  logic [2:0] quiet;
  logic [7:0] pat;
  logic same;
  assign same = role == role_slave && code == rate_select && fmt == format_select;
  assign frame_clock = fcnt[6];
  assign mod_left_bit = pat[0];
  assign mod_right_bit = pat[4];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcnt <= 7'h00;
      quiet <= 3'h0;
      pat <= 8'h5a;
      power_good <= 1'b0;
      reset_pin_n <= 1'b0;
      role_slave <= 1'b0;
      rate_select <= 3'h0;
      format_select <= 2'h0;
    end else begin
      fcnt <= fcnt + 7'h01;
      pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[0]};
      power_good <= pg && (power_good || quiet >= 3'h3);
      if (!same) begin
        // Pins move only one clock after reset is seen low
        reset_pin_n <= 1'b0;
        quiet <= 3'h0;
        if (!reset_pin_n) begin
          role_slave <= role;
          rate_select <= code;
          format_select <= fmt;
        end
      end else begin
        quiet <= (quiet == 3'h7) ? quiet : quiet + 3'h1;
        reset_pin_n <= run && quiet >= 3'h3;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/adcrs_sequencer_tb.sv
`default_nettype none
module adcrs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 128;
  logic aclk, aresetn, run, pg, role, power_good, reset_pin_n, role_slave, frame_clock, mod_l, mod_r;
  logic [2:0] code, rsel;
  logic [1:0] fmt, fsel, rate_class, bresp, rresp, r;
  logic [7:0] mod_ratio;
  logic [9:0] sys_ratio;
  logic stream, cfg_err, reset_active, output_zero, data_valid, powered_down, strobe, sl, sr;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int errors, tests_run, n;

  adcrs_sequencer #(.SETTLE_PERIODS(4), .POWERDOWN_PERIODS(8)) adcrs_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .power_good(power_good), .reset_pin_n(reset_pin_n), .role_slave(role_slave),
    .rate_select_bit2(rsel[2]), .rate_select_bit1(rsel[1]), .rate_select_bit0(rsel[0]),
    .format_select_bit1(fsel[1]), .format_select_bit0(fsel[0]), .frame_clock(frame_clock),
    .mod_left_bit(mod_l), .mod_right_bit(mod_r), .rate_class(rate_class), .mod_ratio(mod_ratio),
    .sys_ratio(sys_ratio), .one_bit_stream_mode(stream), .config_error(cfg_err), .reset_active(reset_active),
    .output_zero(output_zero), .data_valid(data_valid), .powered_down(powered_down), .sample_strobe(strobe),
    .stream_left_out(sl), .stream_right_out(sr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  adcrs_host_model adcrs_host_model_i (.aclk(aclk), .aresetn(aresetn), .run(run), .pg(pg), .role(role),
    .code(code), .fmt(fmt), .power_good(power_good), .reset_pin_n(reset_pin_n), .role_slave(role_slave),
    .rate_select(rsel), .format_select(fsel), .frame_clock(frame_clock), .mod_left_bit(mod_l),
    .mod_right_bit(mod_r));

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return data_valid;
      1: return powered_down;
      default: return !reset_active;
    endcase
  endfunction

  task automatic wait_on(input int s, input int lim);
    n = 0;
    while (sig(s) !== 1'b1 && n < lim) begin
      @(negedge aclk);
      n++;
    end
  endtask

  task automatic host(input logic rl, input logic [2:0] c, input logic [1:0] f, input logic go);
    @(posedge aclk);
    role <= rl;
    code <= c;
    fmt <= f;
    run <= go;
    repeat (8) @(negedge aclk);
  endtask

  // Ready is seen mid-cycle, ahead of its edge
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    logic pa = 1'b1, pw = 1'b1, pb = 1'b1;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pb && n < 100) begin
      @(negedge aclk);
      if (bvalid === 1'b1) begin
        r = bresp;
        pb = 1'b0;
      end
      pa = pa && awready !== 1'b1;
      pw = pw && wready !== 1'b1;
      @(posedge aclk);
      awvalid <= pa;
      wvalid <= pw;
      bready <= pb;
      n++;
    end
    chk(!pb, "write timeout");
  endtask

  task automatic axr(input logic [3:0] a);
    logic pa = 1'b1, pr = 1'b1;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (pr && n < 100) begin
      @(negedge aclk);
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        pr = 1'b0;
      end
      pa = pa && arready !== 1'b1;
      @(posedge aclk);
      arvalid <= pa;
      rready <= pr;
      n++;
    end
    chk(!pr, "read timeout");
  endtask

  task automatic t_decode();
    logic [9:0] sys [8];
    logic [1:0] rc [8];
    logic [7:0] mr [3];
    sys = '{adcrs_pkg::ADCRS_FS768, adcrs_pkg::ADCRS_FS512, adcrs_pkg::ADCRS_FS384, adcrs_pkg::ADCRS_FS256,
      adcrs_pkg::ADCRS_FS384, adcrs_pkg::ADCRS_FS256, adcrs_pkg::ADCRS_FS192, adcrs_pkg::ADCRS_FS128};
    rc = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    mr = '{adcrs_pkg::ADCRS_MOD_X128, adcrs_pkg::ADCRS_MOD_X64, adcrs_pkg::ADCRS_MOD_X32};
    chk(reset_active === 1'b1 && output_zero === 1'b1 && data_valid === 1'b0, "reset outputs");
    for (int i = 0; i < 8; i++) begin
      host(1'b0, 3'(i), 2'h0, 1'b0);
      chk(sys_ratio === sys[i] && rate_class === rc[i] && mod_ratio === mr[rc[i]] && cfg_err === 1'b0, "decode");
    end
    host(1'b0, 3'h4, 2'h3, 1'b0);
    chk(stream === 1'b1 && mod_ratio === adcrs_pkg::ADCRS_MOD_X64 && cfg_err === 1'b0, "stream 100");
    host(1'b0, 3'h7, 2'h3, 1'b0);
    chk(cfg_err === 1'b1, "stream bad code");
    host(1'b1, 3'h0, 2'h3, 1'b0);
    chk(cfg_err === 1'b1 && stream === 1'b0, "slave stream");
    $display("end decode");
  endtask

  task automatic t_release(input logic [2:0] c, input logic [1:0] f, input int per);
    int k = 0, m = 0;
    logic pl, pq;
    host(1'b0, c, f, 1'b0);
    @(posedge aclk);
    run <= 1'b1;
    wait_on(2, 2 * per);
    chk(n <= per + 8, "release late");
    wait_on(0, 8 * per);
    chk(n >= 4 * per - 4 && n <= 5 * per + 4, "settle count");
    pl = mod_l;
    pq = mod_r;
    repeat (4 * per) begin
      @(negedge aclk);
      if (strobe === 1'b1) k++;
      if (sl !== (pl && (&f)) || sr !== (pq && (&f))) m++;
      pl = mod_l;
      pq = mod_r;
    end
    chk(k == 4 && data_valid === 1'b1, "strobe cadence");
    chk(m == 0, "stream bits");
    $display("end release");
  endtask

  task automatic t_power();
    @(posedge aclk);
    run <= 1'b0;
    wait_on(1, 12 * PER);
    chk(n >= 8 * PER && n <= 9 * PER + 8, "power-down count");
    @(posedge aclk);
    run <= 1'b1;
    wait_on(2, 2 * PER);
    chk(n <= PER + 8 && powered_down === 1'b0, "restart");
    wait_on(0, 8 * PER);
    chk(data_valid === 1'b1, "valid again");
    $display("end power");
  endtask

  task automatic t_slave();
    host(1'b1, 3'h0, 2'h0, 1'b1);
    wait_on(0, 12 * PER);
    chk(data_valid === 1'b1 && sys_ratio === adcrs_pkg::ADCRS_FS128 && rate_class === 2'h0, "slave single");
    host(1'b1, 3'h2, 2'h0, 1'b1);
    wait_on(0, 12 * PER);
    chk(data_valid === 1'b1 && rate_class === 2'h2 && cfg_err === 1'b0, "slave quad");
    host(1'b1, 3'h5, 2'h0, 1'b0);
    chk(cfg_err === 1'b1 && rate_class === 2'h3, "slave reserved");
    $display("end slave");
  endtask

  task automatic t_regs();
    host(1'b0, 3'h7, 2'h0, 1'b1);
    wait_on(0, 12 * PER);
    axr(4'h4);
    chk(r === adcrs_pkg::ADCRS_RESP_OKAY && d[3] === 1'b1 && d[2:0] === 3'h3, "status");
    axr(4'h8);
    chk(d[9:0] === adcrs_pkg::ADCRS_FS128 && d[23:16] === adcrs_pkg::ADCRS_MOD_X32, "config");
    @(posedge aclk);
    pg <= 1'b0;
    repeat (3) @(negedge aclk);
    chk(reset_active === 1'b1 && data_valid === 1'b0, "power not good");
    @(posedge aclk);
    pg <= 1'b1;
    wait_on(0, 12 * PER);
    axw(4'h0, 32'h1);
    repeat (3) @(negedge aclk);
    chk(r === adcrs_pkg::ADCRS_RESP_OKAY && reset_active === 1'b1, "soft hold");
    axr(4'h0);
    chk(d[0] === 1'b1, "ctrl readback");
    axw(4'h0, 32'h0);
    axr(4'h2);
    chk(r === adcrs_pkg::ADCRS_RESP_SLVERR, "unmapped read");
    $display("end regs");
  endtask

  task automatic summarize();
    $display("Counts: %0d compared, %0d mismatched", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Runs take about 10k cycles; wide margin
  initial begin
    #(30000 * 10);
    errors++;
    summarize();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    aresetn = 1'b0;
    run = 1'b0;
    pg = 1'b1;
    role = 1'b0;
    code = 3'h7;
    fmt = 2'h0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'h0;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    t_decode();
    t_release(3'h5, 2'h3, 256);
    t_release(3'h7, 2'h0, PER);
    t_power();
    t_slave();
    t_regs();
    summarize();
  end
endmodule
`default_nettype wire
